// >>> rtl/adcc_params.svh
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// System clock rate; every time below is turned into clk_sys cycles.
`define ADCC_CLK_HZ        25000000
`define ADCC_CLK_MHZ       (`ADCC_CLK_HZ / 1000000)

// Sampling monostable length and its cycle count (250 at 25 MHz).
`define ADCC_SAMPLE_NS     10000
`define ADCC_SAMPLE_CYC    ((`ADCC_SAMPLE_NS * `ADCC_CLK_MHZ) / 1000)

// Internal oscillator rate and its period in cycles (100 at 25 MHz).
`define ADCC_OSC_HZ        250000
`define ADCC_OSC_CYC       (`ADCC_CLK_HZ / `ADCC_OSC_HZ)

// Slowest external clock still seen as present (2500 cycles window).
`define ADCC_EXT_MIN_HZ    10000
`define ADCC_EXT_CYC       (`ADCC_CLK_HZ / `ADCC_EXT_MIN_HZ)

// Conversion clock periods per conversion.
`define ADCC_CONV_TICKS    13

// Result layout.
`define ADCC_RES_W         10
`define ADCC_MSB_POS       4'h9
`define ADCC_LSB_FULL      4'h0
`define ADCC_LSB_RED       4'h2
`define ADCC_MSB_TRIAL     10'h200

// Serial shift index: 0 marks end of conversion, 1..10 carry bits.
`define ADCC_SH_MARK       4'h0
`define ADCC_SH_LAST_BIT   4'hA
`define ADCC_SH_ZEROS      4'hB

// Width of the gray-coded shift-clock edge counter.
`define ADCC_GRAY_W        4

// Counter widths.
`define ADCC_PHASE_W       12
`define ADCC_TICK_W        4

`endif

// >>> rtl/adcc_pkg.sv
package adcc_pkg;

    // Conversion sequencer states.
    typedef enum logic [1:0] {
        ADCC_IDLE   = 2'b00,
        ADCC_SAMPLE = 2'b01,
        ADCC_CONV   = 2'b10
    } adcc_state_t;

endpackage : adcc_pkg

// >>> rtl/adcc_sync.sv
`timescale 1ns/1ps

module adcc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // Two flip-flops per bit; the first stage feeds only the second.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic stage1;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    stage1      <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    stage1      <= async_in[i];
                    sync_out[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule // adcc_sync

// >>> rtl/adcc_top.sv
`timescale 1ns/1ps
`include "adcc_params.svh"

// Overview of operation
// - Start on rising edge of convert condition.
// - Held condition never restarts a conversion.
// - Byte select at start picks 10/8 bits.
// - Reduced result: two low bits forced zero.
// - Converting: done flag high, parallel bus off.
// - Converting: serial out low when selected.
// - Completion: done low, load both registers.
// - Parallel and serial paths serve same result.
// - Word format read drives all ten lines.
// - Byte format read: upper byte or low pair.
// - No start or parallel read when disabled or deselected.
// - Shift clock falling edges shift bits MSB first.
// - After last bit, zeros until deselect.
// - Select falling edge reloads the shift register.
// - Fixed sampling interval before taking sample.
// - Internal oscillator: thirteen periods after sampling.
// - External clock activity blocks internal oscillator.
// - Serial out rises at end, then bits.

module adcc_top #(
    parameter int unsigned SAMPLE_CYC = `ADCC_SAMPLE_CYC,
    parameter int unsigned OSC_CYC    = `ADCC_OSC_CYC,
    parameter int unsigned EXT_CYC    = `ADCC_EXT_CYC,
    parameter int unsigned CONV_TICKS = `ADCC_CONV_TICKS
) (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire logic                   serial_clk,
    input  wire logic                   chip_enable,
    input  wire logic                   chip_select_n,
    input  wire logic                   read_convert_sel,
    input  wire logic                   byte_select,
    input  wire logic                   word_format_sel,
    input  wire logic                   ext_timing_in,
    input  wire logic                   comparator_in,
    output logic      [`ADCC_RES_W-1:0] dac_code,
    output logic                        sample_track,
    output logic                        osc_active,
    output logic                        ext_clock_present,
    output logic                        conversion_done_n,
    output logic      [`ADCC_RES_W-1:0] par_data_out,
    output logic                        par_data_oe,
    output logic                        serial_data_out,
    output logic                        serial_data_oe
);
    import adcc_pkg::*;

    localparam int GW = `ADCC_GRAY_W;
    localparam int PW = `ADCC_PHASE_W;
    localparam int TW = `ADCC_TICK_W;

    adcc_state_t          state;
    logic [6:0]           pins_s;
    logic                 ce_s;
    logic                 csn_s;
    logic                 rc_s;
    logic                 bs_s;
    logic                 wf_s;
    logic                 ext_s;
    logic                 cmp_s;
    logic                 cond_d;
    logic                 csn_d;
    logic                 ext_d;
    logic                 conv_cond;
    logic                 read_cond;
    logic                 start_pulse;
    logic                 cs_fall;
    logic                 ext_rise;
    logic [PW-1:0]        phase_cnt;
    logic [TW-1:0]        tick_cnt;
    logic [PW-1:0]        osc_cnt;
    logic [PW-1:0]        ext_timer;
    logic                 osc_tick;
    logic                 conv_tick;
    logic                 samp_end;
    logic                 done_evt;
    logic                 reduced;
    logic                 sar_busy;
    logic [3:0]           bitpos;
    logic [3:0]           low_pos;
    logic [`ADCC_RES_W-1:0] result;
    logic                 have_result;
    logic [GW-1:0]        sclk_bin;
    logic [GW-1:0]        next_sclk_bin;
    logic [GW-1:0]        sclk_gray;
    logic [GW-1:0]        gray_s;
    logic [GW-1:0]        gray_bin;
    logic [GW-1:0]        gray_prev;
    logic [GW-1:0]        edge_delta;
    logic [3:0]           shift_idx;
    logic [4:0]           shift_sum;

    // Two-stage pin sync; select enters inverted so reset reads as idle.
    adcc_sync #(
        .WIDTH (7)
    ) u_pin_sync (
        .clk      (clk_sys),
        .nrst     (nrst),
        .async_in ({chip_enable, ~chip_select_n, read_convert_sel,
                    byte_select, word_format_sel, ext_timing_in,
                    comparator_in}),
        .sync_out (pins_s)
    );

    assign ce_s  = pins_s[6];
    assign csn_s = ~pins_s[5];
    assign rc_s  = pins_s[4];
    assign bs_s  = pins_s[3];
    assign wf_s  = pins_s[2];
    assign ext_s = pins_s[1];
    assign cmp_s = pins_s[0];

    // Decoded control conditions; both need enable high, select low.
    assign conv_cond = ce_s & ~csn_s & ~rc_s;
    assign read_cond = ce_s & ~csn_s & rc_s;

    // Edge history of the synchronised controls.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cond_d <= 1'b0;
            csn_d  <= 1'b1;
            ext_d  <= 1'b0;
        end else begin
            cond_d <= conv_cond;
            csn_d  <= csn_s;
            ext_d  <= ext_s;
        end
    end

    // Only a fresh rising edge of the condition starts anything.
    assign start_pulse = conv_cond & ~cond_d;
    assign cs_fall     = csn_d & ~csn_s;
    assign ext_rise    = ext_s & ~ext_d;

    // External clock is present while edges keep arriving in the window.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ext_timer <= '0;
        end else if (ext_rise) begin
            ext_timer <= PW'(EXT_CYC);
        end else if (ext_timer != '0) begin
            ext_timer <= ext_timer - 1'b1;
        end
    end

    assign ext_clock_present = (ext_timer != '0);

    // End of the sampling interval and the final conversion period.
    assign samp_end = (state == ADCC_SAMPLE) & ~start_pulse
                    & (phase_cnt == PW'(SAMPLE_CYC - 1));
    assign done_evt = (state == ADCC_CONV) & ~start_pulse & conv_tick
                    & (tick_cnt == TW'(CONV_TICKS - 1));

    // Sequencer: sample for a fixed time, then count conversion periods.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state     <= ADCC_IDLE;
            phase_cnt <= '0;
            tick_cnt  <= '0;
        end else if (start_pulse) begin
            state     <= ADCC_SAMPLE;
            phase_cnt <= '0;
            tick_cnt  <= '0;
        end else begin
            case (state)
                ADCC_IDLE: begin
                    phase_cnt <= '0;
                end
                ADCC_SAMPLE: begin
                    if (samp_end) begin
                        state <= ADCC_CONV;
                    end else begin
                        phase_cnt <= phase_cnt + 1'b1;
                    end
                end
                ADCC_CONV: begin
                    if (done_evt) begin
                        state <= ADCC_IDLE;
                    end else if (conv_tick) begin
                        tick_cnt <= tick_cnt + 1'b1;
                    end
                end
                default: begin
                    state <= ADCC_IDLE;
                end
            endcase
        end
    end

    // Sample switch tracks the input for the whole monostable interval.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sample_track <= 1'b0;
        end else if (start_pulse) begin
            sample_track <= 1'b1;
        end else if (samp_end) begin
            sample_track <= 1'b0;
        end
    end

    // Internal oscillator wakes after sampling unless an external clock
    // runs, and sleeps again after the last conversion period.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            osc_active <= 1'b0;
            osc_cnt    <= '0;
        end else if (start_pulse | done_evt | ext_clock_present) begin
            osc_active <= 1'b0;
            osc_cnt    <= '0;
        end else if (samp_end) begin
            osc_active <= 1'b1;
            osc_cnt    <= '0;
        end else if (osc_active) begin
            if (osc_tick) begin
                osc_cnt <= '0;
            end else begin
                osc_cnt <= osc_cnt + 1'b1;
            end
        end
    end

    assign osc_tick  = osc_active & (osc_cnt == PW'(OSC_CYC - 1));

    // Conversion period source: external rising edges or the oscillator.
    assign conv_tick = (state == ADCC_CONV)
                     & (ext_clock_present ? ext_rise : osc_tick);

    // Lowest bit that the successive approximation resolves.
    assign low_pos = reduced ? `ADCC_LSB_RED : `ADCC_LSB_FULL;

    // Resolution is chosen by byte select at the start edge.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reduced <= 1'b0;
        end else if (start_pulse) begin
            reduced <= bs_s;
        end
    end

    // Successive approximation: one bit decided per conversion period.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dac_code <= '0;
            bitpos   <= `ADCC_MSB_POS;
            sar_busy <= 1'b0;
        end else if (start_pulse) begin
            dac_code <= '0;
            bitpos   <= `ADCC_MSB_POS;
            sar_busy <= 1'b0;
        end else if (samp_end) begin
            dac_code <= `ADCC_MSB_TRIAL;
            bitpos   <= `ADCC_MSB_POS;
            sar_busy <= 1'b1;
        end else if (conv_tick & sar_busy) begin
            dac_code[bitpos] <= cmp_s;
            if (bitpos == low_pos) begin
                sar_busy <= 1'b0;
            end else begin
                dac_code[bitpos - 1'b1] <= 1'b1;
                bitpos                  <= bitpos - 1'b1;
            end
        end
    end

    // Completion stores the result once for both output paths.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            result            <= '0;
            have_result       <= 1'b0;
            conversion_done_n <= 1'b1;
        end else if (start_pulse) begin
            conversion_done_n <= 1'b1;
        end else if (done_evt) begin
            conversion_done_n <= 1'b0;
            have_result       <= 1'b1;
            if (reduced) begin
                result <= {dac_code[9:2], 2'b00};
            end else begin
                result <= dac_code;
            end
        end
    end

    // Parallel port: registered data and enable, only while reading idle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            par_data_oe  <= 1'b0;
            par_data_out <= '0;
        end else begin
            par_data_oe <= read_cond & (state == ADCC_IDLE);
            if (wf_s) begin
                par_data_out <= result;
            end else if (bs_s) begin
                par_data_out <= {result[1:0], 8'h00};
            end else begin
                par_data_out <= {result[9:2], 2'b00};
            end
        end
    end

    // Shift clock domain: falling edges advance a gray-coded counter.
    assign next_sclk_bin = sclk_bin + 1'b1;

    always_ff @(negedge serial_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_bin  <= '0;
            sclk_gray <= '0;
        end else begin
            sclk_bin  <= next_sclk_bin;
            sclk_gray <= next_sclk_bin ^ (next_sclk_bin >> 1);
        end
    end

    // The gray count crosses into clk_sys through two flip-flops.
    adcc_sync #(
        .WIDTH (GW)
    ) u_gray_sync (
        .clk      (clk_sys),
        .nrst     (nrst),
        .async_in (sclk_gray),
        .sync_out (gray_s)
    );

    // Gray to binary, one xor reduction per bit.
    genvar gi;
    generate
        for (gi = 0; gi < GW; gi++) begin : g_gray
            assign gray_bin[gi] = ^gray_s[GW-1:gi];
        end
    endgenerate

    assign edge_delta = gray_bin - gray_prev;
    assign shift_sum  = {1'b0, shift_idx} + {1'b0, edge_delta};

    // Shift position: reloaded at completion and on each select fall,
    // advanced by shift clock edges seen while selected and idle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            gray_prev <= '0;
            shift_idx <= `ADCC_SH_MARK;
        end else begin
            gray_prev <= gray_bin;
            if (done_evt) begin
                shift_idx <= `ADCC_SH_MARK;
            end else if (cs_fall & have_result) begin
                shift_idx <= `ADCC_SH_MARK;
            end else if ((state == ADCC_IDLE) & have_result & ~csn_s) begin
                if (shift_sum > {1'b0, `ADCC_SH_ZEROS}) begin
                    shift_idx <= `ADCC_SH_ZEROS;
                end else begin
                    shift_idx <= shift_sum[3:0];
                end
            end
        end
    end

    // Serial output: low while converting, high marker, bits, then zeros.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            serial_data_out <= 1'b0;
            serial_data_oe  <= 1'b0;
        end else begin
            serial_data_oe <= ~csn_s;
            if ((state != ADCC_IDLE) | ~have_result) begin
                serial_data_out <= 1'b0;
            end else if (shift_idx == `ADCC_SH_MARK) begin
                serial_data_out <= 1'b1;
            end else if (shift_idx <= `ADCC_SH_LAST_BIT) begin
                serial_data_out <= result[`ADCC_SH_LAST_BIT - shift_idx];
            end else begin
                serial_data_out <= 1'b0;
            end
        end
    end

endmodule // adcc_top

// >>> verification/adcc_checker_assertions.sv
`timescale 1ns/1ps

module adcc_checker #(
    parameter int unsigned SAMPLE_CYC = 20,
    parameter int unsigned OSC_CYC    = 10,
    parameter int unsigned CONV_TICKS = 13
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic chip_enable,
    input wire logic chip_select_n,
    input wire logic read_convert_sel,
    input wire logic sample_track,
    input wire logic osc_active,
    input wire logic ext_clock_present,
    input wire logic conversion_done_n,
    input wire logic par_data_oe,
    input wire logic serial_data_out,
    input wire logic serial_data_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    int unsigned st_cnt;
    int unsigned os_cnt;
    logic        rd_pin;

    // Read condition as seen on the pins.
    assign rd_pin = chip_enable & ~chip_select_n & read_convert_sel;

    // Measures how long sampling and the oscillator stay on.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_cnt <= 0;
            os_cnt <= 0;
        end else begin
            st_cnt <= sample_track ? st_cnt + 1 : 0;
            os_cnt <= osc_active ? os_cnt + 1 : 0;
        end
    end

    chk_busy_quiet: assert property (sample_track || osc_active
        |-> conversion_done_n && !par_data_oe)
        else $error("done flag or parallel bus active while busy");
    chk_sample_len: assert property ($fell(sample_track)
        |-> st_cnt == SAMPLE_CYC)
        else $error("sampling interval has wrong length");
    chk_osc_late: assert property (sample_track |-> !osc_active)
        else $error("oscillator runs during sampling");
    chk_osc_ticks: assert property ($fell(osc_active)
        |-> os_cnt == CONV_TICKS * OSC_CYC)
        else $error("oscillator burst has wrong length");
    chk_osc_start: assert property ($fell(sample_track)
        && !ext_clock_present |-> ##[0:2] osc_active)
        else $error("oscillator not started after sampling");
    chk_ext_block: assert property (ext_clock_present
        |-> !$rose(osc_active))
        else $error("oscillator started with external clock");
    chk_done_end: assert property ($fell(osc_active)
        && !ext_clock_present |-> ##[0:2] !conversion_done_n)
        else $error("done flag missing after burst");
    chk_ser_low: assert property (serial_data_oe
        && ((sample_track && $past(sample_track)) || osc_active)
        |-> !serial_data_out)
        else $error("serial output high during conversion");
    chk_ser_oe: assert property (serial_data_oe
        |-> !$past(chip_select_n, 2) || !$past(chip_select_n, 3))
        else $error("serial output driven while deselected");
    chk_par_read: assert property (par_data_oe
        |-> $past(rd_pin, 2) || $past(rd_pin, 3))
        else $error("parallel bus driven outside a read");
endmodule // adcc_checker

// >>> verification/adcc_host_model.sv
`timescale 1ns/1ps
`include "adcc_params.svh"

module adcc_host_model (
    input  wire logic [`ADCC_RES_W-1:0] dac_code,
    input  wire logic [`ADCC_RES_W-1:0] level,
    output logic                        comparator_in,
    output logic                        serial_clk
);
    // The comparator reports whether the held input reaches the trial code.
    assign comparator_in = (level >= dac_code);

    // The shift clock rests low and pulses only when a bit is wanted.
    initial serial_clk = 1'b0;

    // One 7.5 ns shift clock high pulse ending in a falling edge.
    task automatic pulse();
        serial_clk = 1'b1;
        #7.5;
        serial_clk = 1'b0;
    endtask
endmodule // adcc_host_model

// >>> verification/test_adcc_top.sv
`timescale 1ns/1ps

module test_adcc_top;
    localparam int unsigned SAMPLE_CYC = 20;
    localparam int unsigned OSC_CYC    = 10;
    localparam int unsigned EXT_CYC    = 200;
    localparam int unsigned CONV_TICKS = 13;

    logic        clk_sys, nrst, serial_clk, comparator_in;
    logic        chip_enable, chip_select_n, read_convert_sel;
    logic        byte_select, word_format_sel;
    logic        ext_timing_in = 1'b0;
    logic        oe_d = 1'b0;
    logic        sample_track, osc_active, ext_clock_present;
    logic        conversion_done_n, par_data_oe;
    logic        serial_data_out, serial_data_oe;
    logic [9:0]  dac_code, par_data_out, level, r;
    logic [9:0]  exp_q[$];
    logic [31:0] rng;
    logic [6:0]  ext_cnt = 7'h00;
    logic [1:0]  ext_mode;
    int          fail_count, tests_run, i;
    event        ser_ev;

    adcc_top #(.SAMPLE_CYC(SAMPLE_CYC), .OSC_CYC(OSC_CYC),
        .EXT_CYC(EXT_CYC), .CONV_TICKS(CONV_TICKS)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .serial_clk(serial_clk),
        .chip_enable(chip_enable), .chip_select_n(chip_select_n),
        .read_convert_sel(read_convert_sel), .byte_select(byte_select),
        .word_format_sel(word_format_sel), .ext_timing_in(ext_timing_in),
        .comparator_in(comparator_in), .dac_code(dac_code),
        .sample_track(sample_track), .osc_active(osc_active),
        .ext_clock_present(ext_clock_present),
        .conversion_done_n(conversion_done_n),
        .par_data_out(par_data_out), .par_data_oe(par_data_oe),
        .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe));

    adcc_host_model host (.dac_code(dac_code), .level(level),
        .comparator_in(comparator_in), .serial_clk(serial_clk));

    // The system clock toggles every half period.
    always #20 clk_sys = ~clk_sys;

    // External clock: low, free running near 390 kHz, or held high.
    always @(negedge clk_sys) begin
        ext_cnt <= ext_cnt + 7'd1;
        ext_timing_in <= (ext_mode == 2'd1) ? ext_cnt[5] : ext_mode[1];
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic check(input string n, input logic [9:0] s, e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Parallel results are compared as the bus turns on.
    always @(negedge clk_sys) begin
        oe_d <= par_data_oe;
        if (par_data_oe === 1'b1 && oe_d === 1'b0 && exp_q.size() > 0)
            check("par_data_out", par_data_out, exp_q.pop_front());
    end

    // Serial bits are compared once the bench marks them settled.
    always @(ser_ev) begin
        if (exp_q.size() > 0)
            check("serial_data_out", 10'(serial_data_out), exp_q.pop_front());
    end

    task automatic convert(input int how, input logic b,
                           input logic [9:0] lv);
        int k;
        level = lv;
        byte_select = b;
        chip_enable = (how != 0);
        chip_select_n = (how == 1);
        read_convert_sel = (how == 2);
        tick(4);
        chip_enable = 1'b1;
        chip_select_n = 1'b0;
        read_convert_sel = 1'b0;
        tick(2);
        byte_select = ~b;
        tick(3);
        check("conversion_done_n", 10'(conversion_done_n), 10'h001);
        k = 0;
        while (conversion_done_n !== 1'b0 && k < 3000) begin
            tick(1);
            k++;
        end
        check("conversion_done_n", 10'(conversion_done_n), 10'h000);
    endtask

    task automatic read(input logic w, input logic b, input logic [9:0] e);
        chip_enable = 1'b0;
        chip_select_n = 1'b0;
        read_convert_sel = 1'b1;
        word_format_sel = w;
        byte_select = b;
        exp_q.push_back(e);
        tick(3);
        chip_enable = 1'b1;
        tick(6);
        chip_enable = 1'b0;
        tick(4);
        check("par_data_oe", 10'(par_data_oe), 10'h000);
        check("pending", 10'(exp_q.size()), 10'h000);
    endtask

    task automatic ser(input logic p, input logic e);
        if (p) begin
            #3;
            host.pulse();
        end
        tick(6);
        exp_q.push_back(10'(e));
        ->ser_ev;
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A hang is cut short well after the sequence should be over.
    initial begin
        #(40 * 40000);
        fail_count++;
        $display("watchdog expired");
        wrap_up();
    end

    // Main sequence.
    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        chip_enable = 1'b0;
        chip_select_n = 1'b1;
        read_convert_sel = 1'b0;
        byte_select = 1'b0;
        word_format_sel = 1'b0;
        ext_mode = 2'd0;
        level = 10'h000;
        rng = 32'h79a1;
        fail_count = 0;
        tests_run = 0;
        repeat (4) @(negedge clk_sys);
        nrst = 1'b1;
        tick(3);
        rng = xs(rng);
        r = rng[9:0];
        convert(0, 1'b0, r);
        tick(60);
        check("conversion_done_n", 10'(conversion_done_n), 10'h000);
        check("sample_track", 10'(sample_track), 10'h000);
        check("dac_code", dac_code, r);
        check("ext_clock_present", 10'(ext_clock_present), 10'h000);
        ser(1'b0, 1'b1);
        for (i = 9; i >= 0; i--) ser(1'b1, r[i]);
        ser(1'b1, 1'b0);
        ser(1'b1, 1'b0);
        chip_select_n = 1'b1;
        read_convert_sel = 1'b1;
        word_format_sel = 1'b1;
        tick(4);
        check("serial_data_oe", 10'(serial_data_oe), 10'h000);
        exp_q.push_back(r);
        chip_select_n = 1'b0;
        tick(6);
        ser(1'b0, 1'b1);
        ser(1'b1, r[9]);
        read(1'b0, 1'b0, {r[9:2], 2'b00});
        read(1'b0, 1'b1, {r[1:0], 8'h00});
        $display("test enable_start_serial done");
        rng = xs(rng);
        r = rng[9:0];
        convert(1, 1'b1, r);
        read(1'b1, 1'b0, r & 10'h3FC);
        read(1'b1, 1'b1, r & 10'h3FC);
        $display("test select_start_reduced done");
        rng = xs(rng);
        r = rng[9:0];
        convert(2, 1'b0, r);
        read(1'b1, 1'b0, r);
        $display("test read_select_start done");
        for (i = 0; i < 8; i++) begin
            rng = xs(rng);
            chip_enable = rng[0] & rng[1];
            chip_select_n = chip_enable | rng[2];
            read_convert_sel = rng[3];
            byte_select = rng[4];
            tick(5);
            check("sample_track", 10'(sample_track), 10'h000);
            check("par_data_oe", 10'(par_data_oe), 10'h000);
        end
        $display("test disabled done");
        ext_mode = 2'd1;
        tick(300);
        check("ext_clock_present", 10'(ext_clock_present), 10'h001);
        ext_mode = 2'd2;
        rng = xs(rng);
        r = rng[9:0];
        fork
            convert(0, 1'b1, r);
            begin
                tick(40);
                ext_mode = 2'd1;
            end
        join
        read(1'b1, 1'b0, r & 10'h3FC);
        ext_mode = 2'd0;
        $display("test external_clock done");
        wrap_up();
    end
endmodule // test_adcc_top

bind adcc_top adcc_checker #(
    .SAMPLE_CYC(SAMPLE_CYC),
    .OSC_CYC(OSC_CYC),
    .CONV_TICKS(CONV_TICKS)
) chk (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .chip_enable(chip_enable),
    .chip_select_n(chip_select_n),
    .read_convert_sel(read_convert_sel),
    .sample_track(sample_track),
    .osc_active(osc_active),
    .ext_clock_present(ext_clock_present),
    .conversion_done_n(conversion_done_n),
    .par_data_oe(par_data_oe),
    .serial_data_out(serial_data_out),
    .serial_data_oe(serial_data_oe)
);
